/* File: verilog/dcvc_params.svh */
// constants of the dynamic core voltage checker
`ifndef DCVC_PARAMS_SVH
`define DCVC_PARAMS_SVH
// ****************************************
// timing
// ****************************************
`define DCVC_CLK_PERIOD_NS 100
`define DCVC_CHECK_PERIOD_MS 100
`define DCVC_WINDOW_US 1500
`define DCVC_CODE_STEP_MIN_US 5
`define DCVC_SETTLE_NS 1000
`define DCVC_CHECK_PERIOD_CYC ((`DCVC_CHECK_PERIOD_MS * 1000000) / `DCVC_CLK_PERIOD_NS)
`define DCVC_WINDOW_CYC ((`DCVC_WINDOW_US * 1000) / `DCVC_CLK_PERIOD_NS)
`define DCVC_SETTLE_CYC ((`DCVC_SETTLE_NS + `DCVC_CLK_PERIOD_NS - 1) / `DCVC_CLK_PERIOD_NS)
// ****************************************
// averaging
// ****************************************
`define DCVC_SAMPLE_LOG2 7
`define DCVC_SAMPLES 128
// ****************************************
// code to reading lookup
// ****************************************
`define DCVC_LSB_UV 6250
`define DCVC_UPPER_CAP_UV 1587500
`define DCVC_UPPER_CAP 9'((`DCVC_UPPER_CAP_UV) / (`DCVC_LSB_UV))
`define DCVC_CODE_BASE 8'hf0
`define DCVC_CODE_STEP 8'h02
`define DCVC_CODE_OFF 6'h3f
// ****************************************
// reset values
// ****************************************
`define DCVC_CODE_RST 6'h00
`define DCVC_AVG_RST 8'h00
`endif

/* File: verilog/dcvc_pkg.sv */
// types of the dynamic core voltage checker
package dcvc_pkg;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } dcvc_pair_t;

  typedef struct packed {
    logic done;
    logic skipped;
    logic dyn_high;
    logic dyn_low;
    logic stat_high;
    logic stat_low;
  } dcvc_result_t;

  typedef enum logic [2:0] {
    DCVC_ST_WINDOW = 3'h1,
    DCVC_ST_CHECK  = 3'h2,
    DCVC_ST_WAIT   = 3'h4
  } dcvc_state_t;
endpackage

/* File: verilog/dcvc_top.sv */
// dynamic core voltage window checker for two processors
//
// Operation
// - channel one and two follow own codes
// - static compare runs beside dynamic compare
// - code changes assumed 5 us apart
// - skew transients filtered, settled codes only
// - nominal voltage averaged over 1.5 ms
// - compare at conversion end using average
// - upper limit is average plus offset
// - lower limit is average minus offset
// - outside either limit raises error event
// - both comparisons every 100 ms
// - regulator off code in the window skips that dynamic check
// - upper check off above 1.5875 V
`timescale 1ns/100ps
`default_nettype none
`include "dcvc_params.svh"
module dcvc_top #(
  parameter int PERIOD_CYC = `DCVC_CHECK_PERIOD_CYC,
  parameter int WINDOW_CYC = `DCVC_WINDOW_CYC
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_enable,
  input  wire logic [5:0]           i_cpu1_voltage_code_bits,
  input  wire logic [5:0]           i_cpu2_voltage_code_bits,
  input  wire logic [7:0]           i_cpu1_core_rail_input,
  input  wire logic [7:0]           i_cpu2_core_rail_input,
  input  wire dcvc_pkg::dcvc_pair_t i_dyn_offsets,
  input  wire dcvc_pkg::dcvc_pair_t i_cpu1_static_limits,
  input  wire dcvc_pkg::dcvc_pair_t i_cpu2_static_limits,
  output var  dcvc_pkg::dcvc_result_t o_cpu1_result,
  output var  dcvc_pkg::dcvc_result_t o_cpu2_result,
  output logic [7:0]                o_cpu1_avg_level,
  output logic [7:0]                o_cpu2_avg_level
);
  import dcvc_pkg::*;

  localparam int GAP_CYC = WINDOW_CYC / `DCVC_SAMPLES;
  localparam int SUMW    = 8 + `DCVC_SAMPLE_LOG2;

  // ****************************************
  // helpers
  // ****************************************
  // code to nominal reading lookup
  function automatic logic [7:0] code_level(input logic [5:0] code);
    logic [13:0] prod;
    prod = 14'(code) * 14'(`DCVC_CODE_STEP);
    if (prod[13:8] != 6'h00 || prod[7:0] > `DCVC_CODE_BASE) begin
      code_level = 8'h00;
    end else begin
      code_level = `DCVC_CODE_BASE - prod[7:0];
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [5:0]      raw_r      [2];
  logic [5:0]      code_r     [2];
  logic [7:0]      stab_cnt_r [2];
  logic [SUMW-1:0] sum_r      [2];
  logic            off_r      [2];
  logic [7:0]      avg_r      [2];
  logic [5:0]      code_in    [2];
  logic [7:0]      rail_in    [2];
  dcvc_pair_t      stat_in    [2];
  dcvc_result_t    res_r      [2];
  dcvc_state_t     state_r;
  logic [31:0]     period_cnt_r;
  logic [31:0]     gap_cnt_r;
  logic [7:0]      samp_cnt_r;
  logic            period_end;
  logic            sample_tick;

  // channel steering
  assign code_in[0] = i_cpu1_voltage_code_bits;
  assign code_in[1] = i_cpu2_voltage_code_bits;
  assign rail_in[0] = i_cpu1_core_rail_input;
  assign rail_in[1] = i_cpu2_core_rail_input;
  assign stat_in[0] = i_cpu1_static_limits;
  assign stat_in[1] = i_cpu2_static_limits;

  // ****************************************
  // check period timer
  // ****************************************
  assign period_end = (period_cnt_r == 32'(PERIOD_CYC - 1));

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_cnt_r <= 32'h0;
    end else if (!i_enable || period_end) begin
      period_cnt_r <= 32'h0;
    end else begin
      period_cnt_r <= period_cnt_r + 32'h1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  assign sample_tick = (state_r == DCVC_ST_WINDOW)
                    && (gap_cnt_r == 32'(GAP_CYC - 1));

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= DCVC_ST_WAIT;
    end else if (!i_enable) begin
      state_r <= DCVC_ST_WAIT;
    end else begin
      case (state_r)
        DCVC_ST_WAIT: begin
          if (period_end) begin
            state_r <= DCVC_ST_WINDOW;
          end
        end
        DCVC_ST_WINDOW: begin
          if (sample_tick && samp_cnt_r == 8'(`DCVC_SAMPLES - 1)) begin
            state_r <= DCVC_ST_CHECK;
          end
        end
        DCVC_ST_CHECK: begin
          state_r <= DCVC_ST_WAIT;
        end
        default: begin
          state_r <= DCVC_ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt_r  <= 32'h0;
      samp_cnt_r <= 8'h00;
    end else if (state_r != DCVC_ST_WINDOW) begin
      gap_cnt_r  <= 32'h0;
      samp_cnt_r <= 8'h00;
    end else if (sample_tick) begin
      gap_cnt_r  <= 32'h0;
      samp_cnt_r <= samp_cnt_r + 8'h01;
    end else begin
      gap_cnt_r  <= gap_cnt_r + 32'h1;
    end
  end

  // ****************************************
  // per channel code filter and averaging
  // ****************************************
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [8:0] avg_w;
    logic [8:0] hi_lim_w;
    logic [8:0] lo_lim_w;
    logic [8:0] rail_w;

    assign avg_w    = 9'(sum_r[c][SUMW-1:`DCVC_SAMPLE_LOG2]);
    assign hi_lim_w = avg_w + 9'(i_dyn_offsets.upper);
    assign lo_lim_w = avg_w - 9'(i_dyn_offsets.lower);
    assign rail_w   = 9'(rail_in[c]);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        raw_r[c]      <= `DCVC_CODE_RST;
        code_r[c]     <= `DCVC_CODE_RST;
        stab_cnt_r[c] <= 8'h00;
      end else begin
        raw_r[c] <= code_in[c];
        if (code_in[c] != raw_r[c]) begin
          stab_cnt_r[c] <= 8'h00;
        end else if (stab_cnt_r[c] < 8'(`DCVC_SETTLE_CYC - 1)) begin
          stab_cnt_r[c] <= stab_cnt_r[c] + 8'h01;
        end else begin
          code_r[c] <= raw_r[c];
        end
      end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sum_r[c] <= '0;
        off_r[c] <= 1'b0;
      end else if (state_r != DCVC_ST_WINDOW) begin
        sum_r[c] <= '0;
        off_r[c] <= 1'b0;
      end else begin
        if (sample_tick) begin
          sum_r[c] <= sum_r[c] + SUMW'(code_level(code_r[c]));
        end
        if (code_r[c] == `DCVC_CODE_OFF) begin
          off_r[c] <= 1'b1;
        end
      end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        avg_r[c] <= `DCVC_AVG_RST;
        res_r[c] <= '0;
      end else begin
        res_r[c] <= '0;
        if (state_r == DCVC_ST_CHECK) begin
          avg_r[c] <= avg_w[7:0];
          res_r[c].done <= 1'b1;
          res_r[c].stat_high <= rail_in[c] > stat_in[c].upper;
          res_r[c].stat_low  <= rail_in[c] < stat_in[c].lower;
          if (off_r[c]) begin
            res_r[c].skipped <= 1'b1;
          end else begin
            res_r[c].dyn_high <= (hi_lim_w <= `DCVC_UPPER_CAP)
                              && (rail_w > hi_lim_w);
            res_r[c].dyn_low  <= (avg_w >= 9'(i_dyn_offsets.lower))
                              && (rail_w < lo_lim_w);
          end
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    o_cpu1_result    = res_r[0];
    o_cpu2_result    = res_r[1];
    o_cpu1_avg_level = avg_r[0];
    o_cpu2_avg_level = avg_r[1];
  end
endmodule
`default_nettype wire

/* File: dv/dcvc_cpu_model.sv */
// processor voltage code source with line skew on each step
`timescale 1ns/100ps
`default_nettype none
module dcvc_cpu_model #(
  parameter int STEP_CYC = 50
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [5:0] i_target,
  output logic      [5:0] o_code
);
  logic [5:0] code_r;
  logic [5:0] prev_r;
  int         cnt_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_r <= 6'h00;
      prev_r <= 6'h00;
      cnt_r  <= 0;
    end else begin
      cnt_r <= (cnt_r == STEP_CYC - 1) ? 0 : cnt_r + 1;
      if (cnt_r == 0) begin
        prev_r <= code_r;
        if (code_r < i_target) code_r <= code_r + 6'h01;
        else if (code_r > i_target) code_r <= code_r - 6'h01;
      end
    end
  end
  // low lines lead for two cycles
  assign o_code = (cnt_r inside {1, 2}) ? {prev_r[5:3], code_r[2:0]} : code_r;
endmodule
`default_nettype wire

/* File: dv/dcvc_top_asserts.sv */
// port assertions of the dynamic core voltage checker
`timescale 1ns/100ps
`default_nettype none
module dcvc_top_asserts #(
  parameter int PERIOD_CYC = 2000,
  parameter int WINDOW_CYC = 1280
) (
  input wire logic                   i_clock,
  input wire logic                   i_rst_n,
  input wire logic                   i_enable,
  input wire logic [7:0]             i_cpu1_core_rail_input,
  input wire logic [7:0]             i_cpu2_core_rail_input,
  input wire dcvc_pkg::dcvc_pair_t   i_dyn_offsets,
  input wire dcvc_pkg::dcvc_pair_t   i_cpu1_static_limits,
  input wire dcvc_pkg::dcvc_result_t o_cpu1_result,
  input wire dcvc_pkg::dcvc_result_t o_cpu2_result,
  input wire logic [7:0]             o_cpu1_avg_level,
  input wire logic [7:0]             o_cpu2_avg_level
);
  import dcvc_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [8:0] up1;
  logic [8:0] up2;
  dcvc_pair_t offs_q;
  // offsets as the design saw them in its compare cycle
  always_ff @(posedge i_clock) begin
    offs_q <= i_dyn_offsets;
  end
  assign up1 = 9'(o_cpu1_avg_level) + 9'(offs_q.upper);
  assign up2 = 9'(o_cpu2_avg_level) + 9'(offs_q.upper);
  sequence quiet_s; !o_cpu1_result.done [*8]; endsequence
  sequence chk1_s; o_cpu1_result.done && !o_cpu1_result.skipped; endsequence
  sequence chk2_s; o_cpu2_result.done && !o_cpu2_result.skipped; endsequence
  done_once_a: assert property (o_cpu1_result.done |=> quiet_s)
    else $error("result pulse repeated");
  skip_quiet_a: assert property (o_cpu2_result.skipped |->
    !o_cpu2_result.dyn_high && !o_cpu2_result.dyn_low) else $error("skip");
  dyn_high_a: assert property (chk1_s |-> o_cpu1_result.dyn_high ==
    (up1 <= 9'h0fe && 9'($past(i_cpu1_core_rail_input)) > up1))
    else $error("hi1");
  dyn_low_a: assert property (chk1_s |-> o_cpu1_result.dyn_low ==
    (o_cpu1_avg_level >= offs_q.lower && $past(i_cpu1_core_rail_input)
    < o_cpu1_avg_level - offs_q.lower)) else $error("low1");
  cpu2_high_a: assert property (chk2_s |-> o_cpu2_result.dyn_high ==
    (up2 <= 9'h0fe && 9'($past(i_cpu2_core_rail_input)) > up2))
    else $error("hi2");
  static_cmp_a: assert property (o_cpu1_result.done |->
    o_cpu1_result.stat_high == ($past(i_cpu1_core_rail_input) >
    $past(i_cpu1_static_limits.upper))) else $error("static high");
  enable_hold_a: assert property (!i_enable [*3] |->
    !o_cpu1_result.done) else $error("result while disabled");
  bits_done_a: assert property (|o_cpu1_result[4:0] |->
    o_cpu1_result.done) else $error("flag without done");
  avg_hold_a: assert property (!o_cpu1_result.done |->
    $stable(o_cpu1_avg_level)) else $error("average moved");
endmodule
bind dcvc_top dcvc_top_asserts #(.PERIOD_CYC(PERIOD_CYC),
  .WINDOW_CYC(WINDOW_CYC)) dcvc_top_asserts_i (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_enable(i_enable),
  .i_cpu1_core_rail_input(i_cpu1_core_rail_input),
  .i_cpu2_core_rail_input(i_cpu2_core_rail_input),
  .i_dyn_offsets(i_dyn_offsets), .i_cpu1_static_limits(i_cpu1_static_limits),
  .o_cpu1_result(o_cpu1_result), .o_cpu2_result(o_cpu2_result),
  .o_cpu1_avg_level(o_cpu1_avg_level), .o_cpu2_avg_level(o_cpu2_avg_level));
`default_nettype wire

/* File: dv/tb_dynamic_core_voltage_check.sv */
// testbench of the dynamic core voltage checker
`timescale 1ns/100ps
`default_nettype none
module tb_dynamic_core_voltage_check;
  import dcvc_pkg::*;
  logic         i_clock, i_rst_n, i_enable;
  logic [5:0]   tgt1, tgt2, code1, code2;
  logic [7:0]   rail1, rail2, avg1, avg2;
  dcvc_pair_t   offs, stat1, stat2;
  dcvc_result_t res1, res2;
  int           err_count, tests_run;
  longint       t0;
  localparam int PER_CYC = 2000;
  dcvc_top #(.PERIOD_CYC(PER_CYC), .WINDOW_CYC(1280)) dcvc_top_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(i_enable),
    .i_cpu1_voltage_code_bits(code1), .i_cpu2_voltage_code_bits(code2),
    .i_cpu1_core_rail_input(rail1), .i_cpu2_core_rail_input(rail2),
    .i_dyn_offsets(offs), .i_cpu1_static_limits(stat1),
    .i_cpu2_static_limits(stat2), .o_cpu1_result(res1), .o_cpu2_result(res2),
    .o_cpu1_avg_level(avg1), .o_cpu2_avg_level(avg2));
  dcvc_cpu_model dcvc_cpu_model_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_target(tgt1), .o_code(code1));
  dcvc_cpu_model dcvc_cpu_model_i2 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_target(tgt2), .o_code(code2));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic cmp6(input dcvc_result_t got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: flags %b not %b", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: level %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_ns(input longint got, input longint exp);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("mismatch at %0t: span %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    @(posedge i_clock);
    #10;
    while (res1.done !== 1'b1 && n < 5000) begin
      @(posedge i_clock);
      #10;
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      $display("mismatch at %0t: no result within limit", $time);
    end
  endtask
  task automatic run(input logic [7:0] r1, input logic [7:0] r2,
                     input logic [15:0] o);
    rail1 = r1;
    rail2 = r2;
    offs = o;
    wait_done();
    t0 = $time;
    wait_done();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic test_nominal();
    run(8'he0, 8'hd9, 16'h0808);
    cmp_ns($time - t0, longint'(PER_CYC) * 100);
    cmp6(res1, 6'b100000);
    cmp6(res2, 6'b101000);
    cmp8(avg1, 8'he0);
    cmp8(avg2, 8'hd0);
    $display("nominal and high test ended");
  endtask
  task automatic test_low();
    stat1 = 16'hffd8;
    run(8'hd7, 8'hd0, 16'h0808);
    cmp6(res1, 6'b100101);
    cmp6(res2, 6'b100000);
    $display("low test ended");
  endtask
  task automatic test_cap();
    {tgt1, stat1} = {6'h00, 16'hf800};
    run(8'hff, 8'hdf, 16'h0f08);
    cmp6(res1, 6'b100010);
    cmp6(res2, 6'b100000);
    $display("cap test ended");
  endtask
  task automatic test_off();
    tgt2 = 6'h3f;
    run(8'hf0, 8'h00, 16'h0808);
    cmp6(res2, 6'b110000);
    $display("off test ended");
  endtask
  task automatic test_skew();
    {tgt1, tgt2} = {6'h38, 6'h10};
    run(8'h81, 8'hd0, 16'hffff);
    repeat (1018) @(posedge i_clock);
    #10 tgt1 = 6'h37;
    wait_done();
    cmp6(res1, 6'b100000);
    $display("skew test ended");
  endtask
  task automatic test_abort();
    logic [7:0] seen;
    seen = 8'h00;
    repeat (1000) @(posedge i_clock);
    #10 i_enable = 1'b0;
    repeat (10) @(posedge i_clock);
    #10 i_enable = 1'b1;
    repeat (1500) begin
      @(posedge i_clock);
      #10;
      if (res1.done === 1'b1) seen++;
    end
    cmp8(seen, 8'h00);
    wait_done();
    cmp6(res1, 6'b100000);
    cmp8(avg1, 8'h82);
    $display("abort test ended");
  endtask
  initial begin
    {i_rst_n, i_enable, err_count, tests_run} = '0;
    {tgt1, tgt2, rail1, rail2, offs} = {6'h08, 6'h10, 32'h0};
    {stat1, stat2} = {16'hff00, 16'hff00};
    repeat (8) @(posedge i_clock);
    #10 i_rst_n = 1'b1;
    repeat (20) @(posedge i_clock);
    #10 i_enable = 1'b1;
    test_nominal();
    test_low();
    test_cap();
    test_off();
    test_skew();
    test_abort();
    report_and_stop();
  end
  initial begin
    #4000000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
